// File: core/audio_channel_attach_output.sv
// Purpose: four audio channels with attach modulation, dma and direct feed
// Assumes: dma controller answers a word request with dma_ack and dma_data
// Notes: converter outputs are signed sample times volume, 15 bits signed
`timescale 1ns/10ps

// Operation
// - period attach bit n makes channel n drive channel n+1 period
// - volume attach bit n makes channel n drive channel n+1 volume
// - channel 3 attach bits modulate nothing, only mute channel 3
// - single buffer playback restarts the pointer by itself when exhausted
// - dma mode interrupts once length is taken, and again at each buffer restart
// - dma disabled means direct mode, interrupt after each word output
// - direct mode without new word for two intervals holds last sample
// - direct mode uses period and volume registers as dma mode
// - sample bytes are signed, -128 to 127, before volume scaling
// - modulator period expiry writes its word into modulated register
// - volume modulation takes bits 6-0 of the word, ignores upper bits
// - both attach bits set alternate words as volume then period
// - upper byte is output first, then the lower byte
module audio_channel_attach_output
  import audio_attach_pkg::*;
#(
  parameter int addr_w = 8
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // axi4-lite write
  input wire logic [addr_w-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [addr_w-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // dma word requests, one bit per channel
  output logic [3:0] dma_req,
  output logic [3:0] dma_restart,
  input wire logic [3:0] dma_ack,
  input wire logic [15:0] dma_data,
  // converter outputs
  output logic [14:0] dac0,
  output logic [14:0] dac1,
  output logic [14:0] dac2,
  output logic [14:0] dac3,
  // interrupt
  output logic irq
);
  import audio_attach_pkg::*;

  // ********************************
  // register state
  // ********************************
  logic [15:0] attach_reg, attach_next;
  logic [3:0] dmaen_reg, dmaen_next;
  logic [3:0] ists_reg, ists_next;
  logic [3:0] imask_reg, imask_next;
  logic [15:0] per_reg [num_ch];
  logic [15:0] per_next [num_ch];
  logic [6:0] vol_reg [num_ch];
  logic [6:0] vol_next [num_ch];
  logic [15:0] len_reg [num_ch];
  logic [15:0] len_next [num_ch];
  logic [15:0] hold_reg [num_ch];
  logic [15:0] hold_next [num_ch];
  logic [3:0] hold_full_reg, hold_full_next;
  // channel engine state
  ch_state_t st_reg [num_ch];
  ch_state_t st_next [num_ch];
  logic [15:0] pcnt_reg [num_ch];
  logic [15:0] pcnt_next [num_ch];
  logic [15:0] lcnt_reg [num_ch];
  logic [15:0] lcnt_next [num_ch];
  logic [15:0] buf_reg [num_ch];
  logic [15:0] buf_next [num_ch];
  logic [3:0] alt_reg, alt_next;
  logic [1:0] miss_reg [num_ch];
  logic [1:0] miss_next [num_ch];
  logic [14:0] dac_reg [num_ch];
  logic [14:0] dac_next [num_ch];
  logic [3:0] req_reg, req_next;
  logic [3:0] rst_reg, rst_next;
  // bus state
  logic aw_got_reg, aw_got_next, w_got_reg, w_got_next;
  logic [addr_w-1:0] waddr_reg, waddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic irq_reg, irq_next;
  logic awrdy_reg, awrdy_next, wrdy_reg, wrdy_next, ardy_reg, ardy_next;

  function automatic logic is_attached(input logic [15:0] a, input int ch);
    return a[period_attach_lsb+ch] | a[volume_attach_lsb+ch];
  endfunction

  // signed byte times 7-bit volume
  function automatic logic [14:0] scale(input logic [7:0] b, input logic [6:0] v);
    logic signed [15:0] p;
    p = 16'sh0000;
    p = $signed({{8{b[7]}}, b}) * $signed({9'h000, v});
    return p[14:0];
  endfunction

  // ********************************
  // combined next state
  // ********************************
  always_comb
  begin
    logic wr;
    logic [addr_w-1:0] wa;
    int wch;
    logic [1:0] wword;
    logic [3:0] ev;
    attach_next = attach_reg;
    dmaen_next = dmaen_reg;
    imask_next = imask_reg;
    hold_full_next = hold_full_reg;
    alt_next = alt_reg;
    req_next = 4'h0;
    rst_next = 4'h0;
    ev = 4'h0;
    for (int i = 0; i < num_ch; i++)
    begin
      per_next[i] = per_reg[i];
      vol_next[i] = vol_reg[i];
      len_next[i] = len_reg[i];
      hold_next[i] = hold_reg[i];
      st_next[i] = st_reg[i];
      pcnt_next[i] = pcnt_reg[i];
      lcnt_next[i] = lcnt_reg[i];
      buf_next[i] = buf_reg[i];
      miss_next[i] = miss_reg[i];
      dac_next[i] = dac_reg[i];
    end
    // bus write channel capture
    aw_got_next = aw_got_reg | s_axi_awvalid;
    w_got_next = w_got_reg | s_axi_wvalid;
    waddr_next = (s_axi_awvalid & ~aw_got_reg) ? s_axi_awaddr : waddr_reg;
    wdata_next = (s_axi_wvalid & ~w_got_reg) ? s_axi_wdata : wdata_reg;
    bvalid_next = bvalid_reg & ~s_axi_bready;
    bresp_next = bresp_reg;
    wr = aw_got_reg & w_got_reg & ~bvalid_reg;
    wa = waddr_reg;
    wch = 32'(wa[6:4]) - 1;
    wword = wa[3:2];
    if (wr)
    begin
      aw_got_next = 1'b0;
      w_got_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = axi_okay;
      // channel blocks run up to 0x4c, so channel 3 stays reachable
      if (wa[7] || wa[6:4] > 3'h4 || wa[1:0] != 2'b00)
        bresp_next = axi_slverr;
      else if (wa[6:4] == 3'h0)
      begin
        unique case (wa[3:0])
          attach_ctrl_off[3:0]: attach_next = wdata_reg[15:0];
          dma_en_off[3:0]: dmaen_next = wdata_reg[3:0];
          irq_status_off[3:0]: ;
          default: imask_next = wdata_reg[3:0];
        endcase
      end
      else
      begin
        unique case (wword)
          ch_period_word: per_next[wch] = wdata_reg[15:0];
          ch_volume_word: vol_next[wch] = wdata_reg[6:0];
          ch_length_word: len_next[wch] = wdata_reg[15:0];
          default:
          begin
            hold_next[wch] = wdata_reg[15:0];
            hold_full_next[wch] = 1'b1;
          end
        endcase
      end
    end
    // dma words land in the holding latch
    for (int i = 0; i < num_ch; i++)
      if (dma_ack[i] && dmaen_reg[i])
      begin
        hold_next[i] = dma_data;
        hold_full_next[i] = 1'b1;
      end
    // channel engines
    for (int i = 0; i < num_ch; i++)
    begin
      logic att, pa, va, fin;
      logic [15:0] w;
      att = is_attached(attach_reg, i);
      pa = attach_reg[period_attach_lsb+i];
      va = attach_reg[volume_attach_lsb+i];
      fin = (pcnt_reg[i] <= 16'h0001);
      w = buf_reg[i];
      unique case (st_reg[i])
        st_idle:
        begin
          alt_next[i] = 1'b0;
          if (dmaen_reg[i])
          begin
            lcnt_next[i] = len_reg[i];
            ev[i] = 1'b1;
            req_next[i] = 1'b1;
            hold_full_next[i] = 1'b0;
            st_next[i] = st_fetch;
          end
          else if (hold_full_reg[i])
          begin
            buf_next[i] = hold_reg[i];
            hold_full_next[i] = 1'b0;
            pcnt_next[i] = per_reg[i];
            miss_next[i] = 2'h0;
            st_next[i] = st_hi;
          end
        end
        st_fetch:
          if (!dmaen_reg[i])
            st_next[i] = st_idle;
          else if (hold_full_reg[i])
          begin
            buf_next[i] = hold_reg[i];
            hold_full_next[i] = 1'b0;
            pcnt_next[i] = per_reg[i];
            req_next[i] = 1'b1;
            st_next[i] = st_hi;
          end
        st_hi, st_lo:
        begin
          if (!att && i < num_ch)
            dac_next[i] = scale(st_reg[i] == st_hi ? w[15:8] : w[7:0], vol_reg[i]);
          if (att)
            dac_next[i] = 15'h0000;
          pcnt_next[i] = pcnt_reg[i] - 16'h0001;
          if (fin)
          begin
            pcnt_next[i] = per_reg[i];
            if (st_reg[i] == st_hi && !(pa && va && !alt_reg[i] && i < 3))
              st_next[i] = st_lo;
            else
            begin
              st_next[i] = st_hi;
              // modulator word goes to the next channel
              if (i < 3 && pa && va)
              begin
                if (!alt_reg[i])
                  vol_next[(i+1)%num_ch] = w[6:0];
                else
                  per_next[(i+1)%num_ch] = w;
                alt_next[i] = ~alt_reg[i];
              end
              else if (i < 3 && va)
                vol_next[(i+1)%num_ch] = w[6:0];
              else if (i < 3 && pa)
                per_next[(i+1)%num_ch] = w;
              if (dmaen_reg[i])
              begin
                buf_next[i] = hold_reg[i];
                hold_full_next[i] = 1'b0;
                req_next[i] = 1'b1;
                lcnt_next[i] = lcnt_reg[i] - 16'h0001;
                if (lcnt_reg[i] <= 16'h0001)
                begin
                  lcnt_next[i] = len_reg[i];
                  rst_next[i] = 1'b1;
                  ev[i] = 1'b1;
                end
              end
              else
              begin
                ev[i] = 1'b1;
                if (hold_full_reg[i])
                begin
                  buf_next[i] = hold_reg[i];
                  hold_full_next[i] = 1'b0;
                  miss_next[i] = 2'h0;
                end
                else if (miss_reg[i] == 2'h1)
                  st_next[i] = st_idle;
                else
                  miss_next[i] = miss_reg[i] + 2'h1;
              end
            end
          end
          if (!dmaen_reg[i] && st_reg[i] != st_hi && st_reg[i] != st_lo)
            st_next[i] = st_idle;
        end
      endcase
      if (att)
        dac_next[i] = 15'h0000;
    end
    // interrupt status, set wins over write-one clear
    ists_next = ists_reg;
    if (wr && wa == irq_status_off[addr_w-1:0])
      ists_next = ists_reg & ~wdata_reg[3:0];
    ists_next = ists_next | ev;
    irq_next = |(ists_next & imask_next);
    // bus read
    rvalid_next = rvalid_reg & ~s_axi_rready;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (s_axi_arvalid && !rvalid_reg)
    begin
      int rch;
      rch = 32'(s_axi_araddr[6:4]) - 1;
      rvalid_next = 1'b1;
      rresp_next = axi_okay;
      rdata_next = 32'h0000_0000;
      if (s_axi_araddr[7] || s_axi_araddr[6:4] > 3'h4 || s_axi_araddr[1:0] != 2'b00)
        rresp_next = axi_slverr;
      else if (s_axi_araddr[6:4] == 3'h0)
      begin
        unique case (s_axi_araddr[3:0])
          attach_ctrl_off[3:0]: rdata_next = {16'h0000, attach_reg};
          dma_en_off[3:0]: rdata_next = {28'h0000000, dmaen_reg};
          irq_status_off[3:0]: rdata_next = {28'h0000000, ists_reg};
          default: rdata_next = {28'h0000000, imask_reg};
        endcase
      end
      else
      begin
        unique case (s_axi_araddr[3:2])
          ch_period_word: rdata_next = {16'h0000, per_reg[rch]};
          ch_volume_word: rdata_next = {25'h0000000, vol_reg[rch]};
          ch_length_word: rdata_next = {16'h0000, len_reg[rch]};
          default: rdata_next = {12'h000, st_reg[rch], lcnt_reg[rch]};
        endcase
      end
    end
    // readies are flops loaded from the next slot state, so they match the slot state each cycle
    awrdy_next = ~aw_got_next;
    wrdy_next = ~w_got_next;
    ardy_next = ~rvalid_next;
  end

  // ********************************
  // registers
  // ********************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      attach_reg <= attach_ctrl_rst;
      dmaen_reg <= 4'h0;
      ists_reg <= 4'h0;
      imask_reg <= 4'h0;
      hold_full_reg <= 4'h0;
      alt_reg <= 4'h0;
      req_reg <= 4'h0;
      rst_reg <= 4'h0;
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      waddr_reg <= '0;
      wdata_reg <= 32'h0000_0000;
      bvalid_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      bresp_reg <= axi_okay;
      rresp_reg <= axi_okay;
      rdata_reg <= 32'h0000_0000;
      irq_reg <= 1'b0;
      awrdy_reg <= 1'b1;
      wrdy_reg <= 1'b1;
      ardy_reg <= 1'b1;
      for (int i = 0; i < num_ch; i++)
      begin
        per_reg[i] <= period_rst;
        vol_reg[i] <= volume_rst;
        len_reg[i] <= length_rst;
        hold_reg[i] <= 16'h0000;
        st_reg[i] <= st_idle;
        pcnt_reg[i] <= 16'h0000;
        lcnt_reg[i] <= 16'h0000;
        buf_reg[i] <= 16'h0000;
        miss_reg[i] <= 2'h0;
        dac_reg[i] <= 15'h0000;
      end
    end
    else if (clk_en)
    begin
      attach_reg <= attach_next;
      dmaen_reg <= dmaen_next;
      ists_reg <= ists_next;
      imask_reg <= imask_next;
      hold_full_reg <= hold_full_next;
      alt_reg <= alt_next;
      req_reg <= req_next;
      rst_reg <= rst_next;
      aw_got_reg <= aw_got_next;
      w_got_reg <= w_got_next;
      waddr_reg <= waddr_next;
      wdata_reg <= wdata_next;
      bvalid_reg <= bvalid_next;
      rvalid_reg <= rvalid_next;
      bresp_reg <= bresp_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
      irq_reg <= irq_next;
      awrdy_reg <= awrdy_next;
      wrdy_reg <= wrdy_next;
      ardy_reg <= ardy_next;
      for (int i = 0; i < num_ch; i++)
      begin
        per_reg[i] <= per_next[i];
        vol_reg[i] <= vol_next[i];
        len_reg[i] <= len_next[i];
        hold_reg[i] <= hold_next[i];
        st_reg[i] <= st_next[i];
        pcnt_reg[i] <= pcnt_next[i];
        lcnt_reg[i] <= lcnt_next[i];
        buf_reg[i] <= buf_next[i];
        miss_reg[i] <= miss_next[i];
        dac_reg[i] <= dac_next[i];
      end
    end
  end

  // ready is high while the channel slot is free
  assign s_axi_awready = awrdy_reg;
  assign s_axi_wready = wrdy_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = ardy_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign dma_req = req_reg;
  assign dma_restart = rst_reg;
  assign dac0 = dac_reg[0];
  assign dac1 = dac_reg[1];
  assign dac2 = dac_reg[2];
  assign dac3 = dac_reg[3];
  assign irq = irq_reg;
endmodule

// File: shared/audio_attach_pkg.sv
// Purpose: constants for the four-channel attach and sample output block
// Assumes: 32-bit axi4-lite register bus, byte addresses
// Notes: register words are one aligned word each
package audio_attach_pkg;
  localparam int num_ch = 4;
  // register byte offsets
  localparam logic [7:0] attach_ctrl_off = 8'h00;
  localparam logic [7:0] dma_en_off = 8'h04;
  localparam logic [7:0] irq_status_off = 8'h08;
  localparam logic [7:0] irq_mask_off = 8'h0c;
  localparam logic [7:0] ch_base_off = 8'h10;
  localparam logic [7:0] ch_stride = 8'h10;
  // per channel word offsets within a channel block
  localparam logic [1:0] ch_period_word = 2'h0;
  localparam logic [1:0] ch_volume_word = 2'h1;
  localparam logic [1:0] ch_length_word = 2'h2;
  localparam logic [1:0] ch_data_word = 2'h3;
  // attach control field positions
  localparam int period_attach_lsb = 4;
  localparam int volume_attach_lsb = 0;
  // reset values
  localparam logic [15:0] attach_ctrl_rst = 16'h0000;
  localparam logic [15:0] period_rst = 16'h0000;
  localparam logic [6:0] volume_rst = 7'h00;
  localparam logic [15:0] length_rst = 16'h0000;
  localparam logic [1:0] axi_okay = 2'b00;
  localparam logic [1:0] axi_slverr = 2'b10;
  typedef enum logic [3:0] {
    st_idle = 4'b0001,
    st_fetch = 4'b0010,
    st_hi = 4'b0100,
    st_lo = 4'b1000
  } ch_state_t;
endpackage

// File: verif/audio_attach_chk.sv
// Purpose: port-level checks of the attach and sample output block
// Assumes: single clock domain, synchronous active-low reset
// Notes: attach state is not visible here, the bench covers it
`timescale 1ns/10ps
// ****************
// checker
// ****************
module audio_attach_chk (
  // clock, reset, run enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // feed and outputs
  input wire logic [3:0] dma_req,
  input wire logic [3:0] dma_restart,
  input wire logic [14:0] dac0,
  input wire logic [14:0] dac2,
  input wire logic irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_reset_quiet: assert property ($rose(aresetn) |-> !irq && dma_req == 4'h0 && dac0 == 15'h0)
    else $error("outputs not quiet after reset");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped or changed");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
  a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:6] s_axi_bvalid)
    else $error("write answer missing");
  a_restart_req: assert property ((dma_restart & ~dma_req) == 4'h0)
    else $error("restart without word request");
  a_frozen_run: assert property (!clk_en |=> $stable({dac0, dac2, dma_req, irq}))
    else $error("state moved while frozen");
endmodule
bind audio_channel_attach_output audio_attach_chk u_chk (.aclk, .aresetn, .clk_en, .s_axi_awvalid,
  .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .dma_req, .dma_restart, .dac0, .dac2, .irq);

// File: verif/dma_feed.sv
// Purpose: memory feed model answering per-channel word requests
// Assumes: one word served per answer, lowest channel first
// Notes: data bus toggles while no word is offered
`timescale 1ns/10ps
// ****************
// memory feed
// ****************
module dma_feed (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // pacing, high answers slowly
  input wire logic slow,
  // requests
  input wire logic [3:0] dma_req,
  input wire logic [3:0] dma_restart,
  // answers
  output logic [3:0] dma_ack,
  output logic [15:0] dma_data
);
  logic [3:0] pend = 4'h0;
  logic [1:0] ptr [4] = '{default: 2'h0};
  int wait_c = 0;
  always @(posedge aclk)
  begin : serve
    int k;
    int pick;
    pick = -1;
    dma_ack <= 4'h0;
    // stale data must not look valid
    dma_data <= ~dma_data;
    pend = pend | dma_req;
    for (k = 0; k < 4; k++)
      if (dma_restart[k])
        ptr[k] = 2'h0;
    for (k = 3; k >= 0; k--)
      if (pend[k])
        pick = k;
    wait_c++;
    if (!aresetn)
    begin
      pend = 4'h0;
      dma_data <= 16'h0000;
    end
    else if (pick >= 0 && wait_c > (slow ? 6 : 1))
    begin
      dma_ack[pick] <= 1'b1;
      dma_data <= {8'h10, 6'h3c, ptr[pick]};
      ptr[pick] = ptr[pick] + 2'h1;
      pend[pick] = 1'b0;
      wait_c = 0;
    end
  end
endmodule

// File: verif/tb.sv
// Purpose: self-checking bench for the attach and sample output block
// Assumes: register map and timing as handed over
// Notes: channel n block sits at 0x10*(n+1), channel 3 at 0x40
`timescale 1ns/10ps
module tb;
  import audio_attach_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] rst; logic [31:0] wd; logic [31:0] exp; logic [1:0] resp;} row_t;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic clk_en = 1'b1;
  logic slow = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp, wr_resp;
  logic [31:0] s_axi_rdata, rd_data;
  logic [3:0] dma_req, dma_restart, dma_ack;
  logic [15:0] dma_data;
  logic [14:0] dac0, dac1, dac2, dac3;
  int errors = 0;
  int checked = 0;
  row_t rows [6] = '{
    '{attach_ctrl_off, 32'(attach_ctrl_rst), 32'hff, 32'hff, axi_okay},
    '{irq_mask_off, 32'h0, 32'h5, 32'h5, axi_okay},
    '{8'h10, 32'(period_rst), 32'h1ac, 32'h1ac, axi_okay},
    '{8'h24, 32'(volume_rst), 32'hff, 32'h7f, axi_okay},
    '{8'h38, 32'(length_rst), 32'h2, 32'h2, axi_okay},
    '{8'h80, 32'h0, 32'h1234, 32'h0, axi_slverr}};
  audio_channel_attach_output #(.addr_w(8)) dut (.aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .dma_req, .dma_restart, .dma_ack, .dma_data, .dac0, .dac1, .dac2, .dac3, .irq);
  dma_feed u_feed (.aclk, .aresetn, .slow, .dma_req, .dma_restart, .dma_ack, .dma_data);
  always #2 aclk = ~aclk;
  task print_verdict;
    if (errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1)
        break;
    end
    s_axi_bready <= 1'b0;
    wr_resp = s_axi_bresp;
    chk(32'(n < 50), 32'h1, "write handshake");
    if (n == 50)
      print_verdict;
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1)
        break;
    end
    s_axi_rready <= 1'b0;
    rd_data = s_axi_rdata;
    rd_resp = s_axi_rresp;
    chk(32'(n < 50), 32'h1, "read handshake");
    if (n == 50)
      print_verdict;
  endtask
  function automatic logic [14:0] probe(input int s);
    case (s)
      0: return dac0;
      1: return dac1;
      2: return dac2;
      3: return dac3;
      4: return {14'h0, irq};
      default: return {14'h0, dma_restart[2]};
    endcase
  endfunction
  // polls each edge, a miss ends the run
  task automatic wait_eq(input int s, input logic [14:0] v, input int bound, input string what);
    int n;
    for (n = 0; n < bound && probe(s) !== v; n++)
      @(posedge aclk);
    chk(32'(probe(s)), 32'(v), what);
    if (probe(s) !== v)
      print_verdict;
  endtask
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i])
    begin
      rd(rows[i].a);
      chk(rd_data, rows[i].rst, "reset value");
      wr(rows[i].a, rows[i].wd);
      chk(32'(wr_resp), 32'(rows[i].resp), "bresp");
      rd(rows[i].a);
      chk(rd_data, rows[i].exp, "readback");
      chk(32'(rd_resp), 32'(rows[i].resp), "rresp");
    end
    // direct feed on channel 1, its interrupt masked at first
    wr(attach_ctrl_off, 32'h0);
    wr(8'h20, 32'h2);
    wr(8'h24, 32'h2);
    wr(8'h2c, 32'h7f80);
    wait_eq(1, 15'h00fe, 100, "dac1 upper");
    wait_eq(1, 15'h7f00, 100, "dac1 lower");
    repeat (60) @(posedge aclk);
    chk(32'(dac1), 32'h7f00, "dac1 held");
    rd(8'h2c);
    chk(32'(rd_data[19:16]), 32'(st_idle), "ch1 state");
    chk(32'(irq), 32'h0, "irq masked");
    rd(irq_status_off);
    chk(32'(rd_data[1]), 32'h1, "ch1 status");
    wr(irq_mask_off, 32'hf);
    wait_eq(4, 15'h1, 10, "irq raised");
    wr(irq_status_off, 32'hf);
    wait_eq(4, 15'h0, 10, "irq cleared");
    // channel 0 modulates both volume and period of channel 1
    wr(attach_ctrl_off, 32'h11);
    wr(8'h10, 32'd40);
    wr(8'h14, 32'h40);
    wr(8'h1c, 32'hff85);
    // second word queued while the first plays, taken at the first word end
    wr(8'h1c, 32'h0123);
    wait_eq(4, 15'h1, 400, "irq word one");
    chk(32'(dac0), 32'h0, "dac0 muted");
    wr(irq_status_off, 32'hf);
    wait_eq(4, 15'h1, 400, "irq word two");
    rd(8'h24);
    chk(rd_data, 32'h5, "ch1 volume");
    rd(8'h20);
    chk(rd_data, 32'h123, "ch1 period");
    chk(32'(dac0), 32'h0, "dac0 muted");
    // memory feed on channel 2 with automatic restart
    wr(attach_ctrl_off, 32'h0);
    wr(8'h30, 32'd200);
    wr(8'h34, 32'h1);
    wr(irq_status_off, 32'hf);
    wr(dma_en_off, 32'h4);
    wait_eq(4, 15'h1, 20, "irq on start");
    wait_eq(2, 15'h0010, 1000, "dac2 upper");
    slow <= 1'b1;
    clk_en <= 1'b0;
    repeat (5) @(posedge aclk);
    clk_en <= 1'b1;
    wait_eq(2, 15'h7ff0, 1000, "dac2 lower");
    wr(irq_status_off, 32'hf);
    wait_eq(5, 15'h1, 3000, "restart");
    wr(dma_en_off, 32'h0);
    // channel 3 attach bits mute it and touch no other channel
    wr(attach_ctrl_off, 32'h88);
    wr(8'h40, 32'h2);
    wr(8'h44, 32'h40);
    wr(8'h4c, 32'h7f11);
    repeat (20) @(posedge aclk);
    chk(32'(dac3), 32'h0, "dac3 muted");
    rd(irq_status_off);
    chk(32'(rd_data[3]), 32'h1, "ch3 status");
    rd(8'h14);
    chk(rd_data, 32'h40, "ch0 volume kept");
    rd(8'h10);
    chk(rd_data, 32'd40, "ch0 period kept");
    wr(attach_ctrl_off, 32'h0);
    wr(8'h4c, 32'h7f11);
    wait_eq(3, 15'h1fc0, 100, "dac3 upper");
    // reset in mid run must clear outputs and registers
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    chk(32'(dac3), 32'h0, "dac3 after reset");
    chk(32'(irq), 32'h0, "irq after reset");
    rd(attach_ctrl_off);
    chk(rd_data, 32'(attach_ctrl_rst), "attach after reset");
    print_verdict;
  end
endmodule
